// ---- logic/bcl_pkg.sv ----
// package for the bypass changeover and parameter lock block
// assumes a 100 MHz control clock, shared by the main module and its input stage
`default_nettype none
package bcl_pkg;
    localparam int          CLK_MHZ        = 100;
    localparam int          FUNC_W         = 5;
    localparam int          NUM_INPUTS     = 5;
    localparam logic [4:0]  FUNC_CHANGEOVER = 5'h0e;
    localparam logic [4:0]  FUNC_PARAM_LOCK = 5'h0f;
    localparam int          FREQ_W         = 16;
    localparam int          WAIT_W         = 16;
    // wait setting is in units of 0.1 s
    localparam int          WAIT_UNIT_MS   = 100;
    localparam int          TICK_CYCLES    = WAIT_UNIT_MS * 1000 * CLK_MHZ;
    localparam int          TICK_W         = 24;
    localparam logic [23:0] TICK_RST       = 24'h000000;
    localparam logic [15:0] WAIT_RST       = 16'h0000;
    localparam int          LOCK_W         = 2;
    // lock scope codes
    localparam logic [1:0]  SCOPE_ALL_TERM = 2'h0;
    localparam logic [1:0]  SCOPE_FRQ_TERM = 2'h1;
    localparam logic [1:0]  SCOPE_ALL_SOFT = 2'h2;
    localparam logic [1:0]  SCOPE_FRQ_SOFT = 2'h3;
    typedef enum logic [2:0] {
        BCL_NORMAL, BCL_BYPASS, BCL_WAIT, BCL_MATCH, BCL_FREEWAIT
    } bcl_state_e;
endpackage
`default_nettype wire

// ---- logic/bcl_sync_edge.sv ----
// two-stage synchroniser with edge detector for one terminal input
// assumes the input is asynchronous to mclk
`default_nettype none
module bcl_sync_edge (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic clkEn,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge mclk) begin
        if (srst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else if (clkEn) begin
            meta <= pinIn;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level = sync;
    assign rise  = sync & ~prev; // see [R14]
    assign fall  = ~sync & prev; // see [R14]
endmodule
`default_nettype wire

// ---- logic/bcl_bypass_lock.sv ----
// bypass changeover sequencing and parameter lock gating for the drive controller
// assumes settings are static from same-clock logic; terminal pins are asynchronous
// Summary of operation
// [R01] a rising changeover input means the motor already runs on the mains, so output stays suppressed in run mode.
// [R02] a falling changeover input starts the restart wait, then frequency matching, then normal run.
// [R03] after the wait, start and match only when the detected motor frequency exceeds the match threshold.
// [R04] the changeover behaviour follows only an input whose function select holds code 14.
// [R05] while changeover is asserted the motor speed is measured for the later match.
// [R06] the outside sequencer closes the bypass contactor first and the supply contactor 0.5 to 1 s later.
// [R07] the outside sequencer opens the bypass contactor then closes the output contactor 0.5 to 1 s later.
// [R08] the outside controller asserts forward run before asserting changeover and closing the supply contactor.
// [R09] while the lock input is asserted every parameter edit is refused, output frequency possibly excepted.
// [R10] with the lock input released and a terminal lock scope (code 0 or 1) selected, parameter edits are accepted and stored.
// [R11] the lock scope setting decides if output frequency stays editable during the lock.
// [R12] the lock gates edits from both the keypad and remote programming sources.
// [R13] the lock scope setting alone can lock parameters without any lock terminal.
// [R14] terminal inputs are synchronised and edges found from successive synchronised samples.
`default_nettype none
module bcl_bypass_lock
    import bcl_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              srst,
    input  wire logic              clkEn,
    input  wire logic [4:0]        terminalIn,
    input  wire logic [4:0]        input1FunctionSelect,
    input  wire logic [4:0]        input2FunctionSelect,
    input  wire logic [4:0]        input3FunctionSelect,
    input  wire logic [4:0]        input4FunctionSelect,
    input  wire logic [4:0]        input5FunctionSelect,
    input  wire logic              forwardRunInput,
    input  wire logic              reverseRunInput,
    input  wire logic [15:0]       restartWaitTimeSetting,
    input  wire logic [15:0]       freqMatchThresholdSetting,
    input  wire logic [1:0]        lockScopeSetting,
    input  wire logic [15:0]       motorFreqDetected,
    input  wire logic              keypadEditReq,
    input  wire logic              keypadEditIsFreq,
    input  wire logic              remoteEditReq,
    input  wire logic              remoteEditIsFreq,
    output logic                   outputSuppress,
    output logic                   speedMeasureEn,
    output logic                   freqMatchStart,
    output logic [15:0]            matchFreq,
    output logic                   runResumed,
    output logic                   keypadEditAccept,
    output logic                   keypadEditReject,
    output logic                   remoteEditAccept,
    output logic                   remoteEditReject,
    output logic                   paramLocked
);
    logic [4:0]  termLevel;
    logic [4:0]  termRise;
    logic [4:0]  termFall;
    logic [4:0]  csSel;
    logic [4:0]  lockSel;
    logic [4:0]  fsel [NUM_INPUTS];
    logic        fwdSync1;
    logic        fwdSync;
    logic        revSync1;
    logic        revSync;
    logic        csRise;
    logic        csFall;
    logic        csLevel;
    logic        lockLevel;
    logic        runCmd;
    bcl_state_e  state;
    bcl_state_e  next_state;
    logic [23:0] tickCnt;
    logic [15:0] waitCnt;
    logic        tick;
    logic        waitDone;
    logic        lockAll;
    logic        lockFreq;
    logic        lockActive;

    assign fsel[0] = input1FunctionSelect;
    assign fsel[1] = input2FunctionSelect;
    assign fsel[2] = input3FunctionSelect;
    assign fsel[3] = input4FunctionSelect;
    assign fsel[4] = input5FunctionSelect;

    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_term
        bcl_sync_edge u_sync (
            .mclk  (mclk),
            .srst  (srst),
            .clkEn (clkEn),
            .pinIn (terminalIn[i]),
            .level (termLevel[i]),
            .rise  (termRise[i]),
            .fall  (termFall[i])
        );
        assign csSel[i]   = (fsel[i] == FUNC_CHANGEOVER); // see [R04]
        assign lockSel[i] = (fsel[i] == FUNC_PARAM_LOCK);
    end

    // run commands are pins too, so they get the same two-stage treatment
    always_ff @(posedge mclk) begin
        if (srst) begin
            fwdSync1 <= 1'b0;
            fwdSync  <= 1'b0;
            revSync1 <= 1'b0;
            revSync  <= 1'b0;
        end else if (clkEn) begin
            fwdSync1 <= forwardRunInput;
            fwdSync  <= fwdSync1;
            revSync1 <= reverseRunInput;
            revSync  <= revSync1;
        end
    end

    // several inputs on the same function act as a wired-or
    assign csRise    = |(termRise & csSel);  // see [R14]
    assign csFall    = |(termFall & csSel);  // see [R14]
    assign csLevel   = |(termLevel & csSel);
    assign lockLevel = |(termLevel & lockSel);
    // forward run is expected before changeover, so no extra interlock here
    assign runCmd    = fwdSync | revSync;     // see [R08]

    // restart wait timebase; held cleared outside the wait state
    assign tick     = (tickCnt == 24'(TICK_CYCLES - 1));
    assign waitDone = (waitCnt >= restartWaitTimeSetting);

    // clearing only under clkEn keeps the counters frozen along with the rest of the state
    always_ff @(posedge mclk) begin
        if (srst) begin
            tickCnt <= TICK_RST;
            waitCnt <= WAIT_RST;
        end else if (clkEn) begin
            if (state != BCL_WAIT) begin
                tickCnt <= TICK_RST;
                waitCnt <= WAIT_RST;
            end else if (tick) begin
                tickCnt <= TICK_RST;
                waitCnt <= waitCnt + 16'h0001;
            end else begin
                tickCnt <= tickCnt + 24'h000001;
            end
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            BCL_NORMAL:
                if (csRise) next_state = BCL_BYPASS;             // see [R01]
            BCL_BYPASS:
                if (csFall) next_state = BCL_WAIT;               // see [R02]
            BCL_WAIT:
                if (csRise) begin
                    next_state = BCL_BYPASS;
                end else if (waitDone) begin
                    // at or below threshold the drive keeps its output off
                    if (motorFreqDetected > freqMatchThresholdSetting) begin
                        next_state = BCL_MATCH;                  // see [R03]
                    end else begin
                        next_state = BCL_FREEWAIT;
                    end
                end
            BCL_MATCH:
                next_state = BCL_NORMAL;                         // see [R02]
            BCL_FREEWAIT:
                if (csRise) begin
                    next_state = BCL_BYPASS;
                end else if (motorFreqDetected > freqMatchThresholdSetting) begin
                    next_state = BCL_MATCH;                      // see [R03]
                end
            default:
                next_state = BCL_NORMAL;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= BCL_NORMAL;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    // changeover outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            outputSuppress <= 1'b0;
            speedMeasureEn <= 1'b0;
            freqMatchStart <= 1'b0;
            matchFreq      <= 16'h0000;
            runResumed     <= 1'b0;
        end else if (clkEn) begin
            outputSuppress <= (next_state != BCL_NORMAL) && runCmd;        // see [R01]
            speedMeasureEn <= (next_state == BCL_BYPASS) && csLevel;       // see [R05]
            freqMatchStart <= (next_state == BCL_MATCH);                   // see [R02]
            if (next_state == BCL_MATCH) begin
                matchFreq <= motorFreqDetected;                            // see [R02]
            end
            runResumed     <= (state == BCL_MATCH);
        end
    end

    // lock: software-only scopes lock without any terminal
    assign lockActive = lockLevel
                      || lockScopeSetting == SCOPE_ALL_SOFT
                      || lockScopeSetting == SCOPE_FRQ_SOFT;                  // see [R13]
    assign lockAll    = lockActive;                                          // see [R09]
    assign lockFreq   = lockActive && (lockScopeSetting == SCOPE_ALL_TERM ||
                                       lockScopeSetting == SCOPE_ALL_SOFT); // see [R11]

    // both edit sources go through the same gate
    always_ff @(posedge mclk) begin
        if (srst) begin
            keypadEditAccept <= 1'b0;
            keypadEditReject <= 1'b0;
            remoteEditAccept <= 1'b0;
            remoteEditReject <= 1'b0;
            paramLocked      <= 1'b0;
        end else if (clkEn) begin
            keypadEditAccept <= keypadEditReq &&
                                !(keypadEditIsFreq ? lockFreq : lockAll);   // see [R10]
            keypadEditReject <= keypadEditReq &&
                                (keypadEditIsFreq ? lockFreq : lockAll);    // see [R12]
            remoteEditAccept <= remoteEditReq &&
                                !(remoteEditIsFreq ? lockFreq : lockAll);   // see [R10]
            remoteEditReject <= remoteEditReq &&
                                (remoteEditIsFreq ? lockFreq : lockAll);    // see [R12]
            paramLocked      <= lockActive;                                  // see [R09]
        end
    end
endmodule
`default_nettype wire

// ---- dv/bcl_contactor_model.sv ----
// behavioural contactor sequencer and run relays facing the changeover input
// assumes bypassReq comes from the bench; contactor delays are scaled to a few cycles
`default_nettype none
module bcl_contactor_model (
    input  wire logic mclk,
    input  wire logic bypassReq,
    output logic      fwdRun,
    output logic      csPin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fwdRun = 1'b0;
        csPin = 1'b0;
        forever begin
            @(posedge bypassReq);
            // run relay first so the drive never sees changeover without a run command
            fwdRun = 1'b1;
            repeat (5) @(negedge mclk);
            csPin = 1'b1;
            @(negedge bypassReq);
            repeat (5) @(negedge mclk);
            csPin = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- dv/bcl_bypass_lock_properties.sv ----
// concurrent checks on the ports of the changeover and lock block
// assumes a single mclk domain with synchronous srst
`default_nettype none
module bcl_bypass_lock_checker (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        keypadEditReq,
    input wire logic        keypadEditIsFreq,
    input wire logic        remoteEditReq,
    input wire logic        remoteEditIsFreq,
    input wire logic [1:0]  lockScopeSetting,
    input wire logic [15:0] freqMatchThresholdSetting,
    input wire logic        freqMatchStart,
    input wire logic [15:0] matchFreq,
    input wire logic        runResumed,
    input wire logic        outputSuppress,
    input wire logic        speedMeasureEn,
    input wire logic        keypadEditAccept,
    input wire logic        keypadEditReject,
    input wire logic        remoteEditAccept,
    input wire logic        remoteEditReject,
    input wire logic        paramLocked
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_edit_answer: assert property (keypadEditReq |=> keypadEditAccept != keypadEditReject)
        else $error("keypad edit not answered exactly once");
    a_no_spurious: assert property (!keypadEditReq && !remoteEditReq
        |=> !(keypadEditAccept || keypadEditReject || remoteEditAccept || remoteEditReject))
        else $error("edit answer without request");
    a_lock_rejects: assert property (keypadEditReq && !keypadEditIsFreq && paramLocked ##1 paramLocked
        |-> keypadEditReject) else $error("locked keypad edit accepted");
    a_remote_locked: assert property (remoteEditReq && !remoteEditIsFreq && paramLocked ##1 paramLocked
        |-> remoteEditReject) else $error("locked remote edit accepted");
    a_unlock_accepts: assert property (keypadEditReq && !paramLocked ##1 !paramLocked
        |-> keypadEditAccept) else $error("unlocked edit rejected");
    a_freq_exempt: assert property (remoteEditReq && remoteEditIsFreq && lockScopeSetting[0]
        |=> remoteEditAccept) else $error("exempt frequency edit rejected");
    a_soft_lock: assert property (lockScopeSetting[1] [*2] |=> paramLocked)
        else $error("soft lock scope did not lock");
    a_match_above: assert property (freqMatchStart |-> matchFreq > freqMatchThresholdSetting)
        else $error("match started at or below threshold");
    a_match_resume: assert property (freqMatchStart |=> runResumed && !outputSuppress && !freqMatchStart)
        else $error("run not resumed after match");
    c_match: cover property (freqMatchStart);
    c_reject: cover property (keypadEditReject && paramLocked);
    c_measure: cover property (speedMeasureEn);
endmodule
bind bcl_bypass_lock bcl_bypass_lock_checker bcl_bypass_lock_checker_inst (.mclk(mclk), .srst(srst),
    .keypadEditReq(keypadEditReq), .keypadEditIsFreq(keypadEditIsFreq), .remoteEditReq(remoteEditReq),
    .remoteEditIsFreq(remoteEditIsFreq), .lockScopeSetting(lockScopeSetting),
    .freqMatchThresholdSetting(freqMatchThresholdSetting), .freqMatchStart(freqMatchStart),
    .matchFreq(matchFreq), .runResumed(runResumed), .outputSuppress(outputSuppress),
    .speedMeasureEn(speedMeasureEn), .keypadEditAccept(keypadEditAccept), .keypadEditReject(keypadEditReject),
    .remoteEditAccept(remoteEditAccept), .remoteEditReject(remoteEditReject), .paramLocked(paramLocked));
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench: random lock and edit traffic, then changeover sequences
// assumes restart wait 0 so the match follows the changeover release at once
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, srst = 1'b1, bypassReq = 1'b0, fwdRun, csPin, kReq = 1'b0, kFrq = 1'b0, rReq = 1'b0;
    logic rFrq = 1'b0, outputSuppress, speedMeasureEn, freqMatchStart, runResumed, kAcc, kRej, rAcc, rRej, paramLocked;
    logic [4:1] pins = 4'h0;
    logic clkEn = 1'b1, revRun = 1'b0;
    logic [15:0] waitSet = 16'h0000, thresh = 16'h0100;
    logic [1:0] scope = 2'h0;
    logic [15:0] motor = 16'h0000, matchFreq;
    logic [31:0] rnd = 32'hba65;
    int numErrors = 0, samplesChecked = 0, seen;
    always #5 mclk = ~mclk;
    bcl_contactor_model bcl_contactor_model_inst (.mclk(mclk), .bypassReq(bypassReq), .fwdRun(fwdRun), .csPin(csPin));
    bcl_bypass_lock bcl_bypass_lock_inst (.mclk(mclk), .srst(srst), .clkEn(clkEn), .terminalIn({pins, csPin}),
        .input1FunctionSelect(5'h0e), .input2FunctionSelect(5'h10), .input3FunctionSelect(5'h0f),
        .input4FunctionSelect(5'h00), .input5FunctionSelect(5'h0e), .forwardRunInput(fwdRun),
        .reverseRunInput(revRun), .restartWaitTimeSetting(waitSet), .freqMatchThresholdSetting(thresh),
        .lockScopeSetting(scope), .motorFreqDetected(motor), .keypadEditReq(kReq), .keypadEditIsFreq(kFrq),
        .remoteEditReq(rReq), .remoteEditIsFreq(rFrq), .outputSuppress(outputSuppress),
        .speedMeasureEn(speedMeasureEn), .freqMatchStart(freqMatchStart), .matchFreq(matchFreq),
        .runResumed(runResumed), .keypadEditAccept(kAcc), .keypadEditReject(kRej), .remoteEditAccept(rAcc),
        .remoteEditReject(rRej), .paramLocked(paramLocked));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic expRej(input logic isFreq);
        return (scope[1] | pins[2]) & ~(isFreq & scope[0]);
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            numErrors++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reportAndStop;
        if (numErrors == 0 && samplesChecked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // bounded wait at falling edges: sel 1 for match start, 0 for suppression
    task automatic waitHigh(input bit sel, input int limit);
        int n;
        for (n = 0; n < limit; n++) begin
            @(negedge mclk);
            if ((sel ? freqMatchStart : outputSuppress) === 1'b1) return;
        end
        numErrors++;
        reportAndStop();
    endtask
    task automatic changeover(input logic [15:0] mot);
        motor = mot;
        bypassReq = 1'b1;
        waitHigh(1'b0, 20);
        check(16'(speedMeasureEn), 16'h1);
        repeat (4) @(negedge mclk);
        check(16'(outputSuppress), 16'h1);
        bypassReq = 1'b0;
    endtask
    initial begin
        repeat (6) @(negedge mclk);
        srst = 1'b0;
        @(negedge mclk);
        check(16'({outputSuppress, kAcc, rRej, paramLocked}), 16'h0);
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            scope = (i < 4) ? 2'(i) : rnd[1:0];
            pins[2] = rnd[2];
            repeat (5) @(negedge mclk);
            check(16'(paramLocked), 16'(scope[1] | pins[2]));
            for (int j = 0; j < 8; j++) begin
                rnd = lfsr(rnd);
                kReq = rnd[0] | (j == 7);
                kFrq = rnd[1] | (j == 7);
                rReq = rnd[2] | (j > 5);
                rFrq = rnd[3];
                @(negedge mclk);
                check(16'({kAcc, kRej}), 16'({kReq & ~expRej(kFrq), kReq & expRej(kFrq)}));
                check(16'({rAcc, rRej}), 16'({rReq & ~expRej(rFrq), rReq & expRej(rFrq)}));
            end
        end
        {kReq, rReq, pins[2]} = 3'h0;
        rnd = lfsr(rnd);
        changeover({8'h02, rnd[7:0]});
        waitHigh(1'b1, 40);
        check(matchFreq, {8'h02, rnd[7:0]});
        @(negedge mclk);
        check(16'({runResumed, outputSuppress}), 16'h2);
        pins[1] = 1'b1;
        repeat (10) @(negedge mclk);
        check(16'(outputSuppress), 16'h0);
        pins[1] = 1'b0;
        changeover(16'h0100);
        seen = 0;
        repeat (30) @(negedge mclk) seen += freqMatchStart;
        check(16'({seen[0], outputSuppress}), 16'h1);
        // a frozen block must not start the match even with the motor above threshold
        clkEn = 1'b0;
        motor = 16'h0300;
        repeat (5) @(negedge mclk);
        check(16'({freqMatchStart, outputSuppress}), 16'h1);
        clkEn = 1'b1;
        waitHigh(1'b1, 10);
        check(matchFreq, 16'h0300);
        reportAndStop();
    end
endmodule
`default_nettype wire
